//--- watchdog_pkg.sv
// shared constants, types and helpers for the start-up configured watchdog pair
package watchdog_pkg;

	// apb register byte offsets
	localparam logic [7:0] IND_REFRESH_OFS = 8'h00;
	localparam logic [7:0] PER_REFRESH_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] IND_COUNT_OFS = 8'h0C;
	localparam logic [7:0] PER_COUNT_OFS = 8'h10;
	localparam logic [7:0] OPTION0_OFS = 8'h14;
	localparam logic [7:0] OPTION1_OFS = 8'h18;

	// value that must be written to a refresh register
	localparam logic [31:0] REFRESH_KEY = 32'h0000_5A5A;

	// status bit positions
	localparam int ST_IND_RUN = 0;
	localparam int ST_PER_RUN = 1;
	localparam int ST_IND_UNDERFLOW = 2;
	localparam int ST_IND_REFRESH_ERR = 3;
	localparam int ST_PER_UNDERFLOW = 4;
	localparam int ST_PER_REFRESH_ERR = 5;

	// option word field positions (same layout in both words)
	localparam int OPT_AUTO_START = 0;
	localparam int OPT_TIMEOUT_LSB = 1;
	localparam int OPT_DIV_LSB = 3;
	localparam int OPT_WIN_END_LSB = 6;
	localparam int OPT_WIN_START_LSB = 8;
	localparam int OPT_ACTION_NMI = 10;
	localparam int OPT_STOP_ENABLE = 11;

	// timeout lengths in divided count clock cycles
	localparam logic [14:0] TIMEOUT_1024 = 15'h0400;
	localparam logic [14:0] TIMEOUT_4096 = 15'h1000;
	localparam logic [14:0] TIMEOUT_8192 = 15'h2000;
	localparam logic [14:0] TIMEOUT_16384 = 15'h4000;

	// one watchdog's start-up settings
	typedef struct packed {
		logic auto_start;
		logic [1:0] timeout_sel;
		logic [2:0] div_sel;
		logic [1:0] win_end;
		logic [1:0] win_start;
		logic action_nmi;
		logic stop_enable;
	} watchdog_cfg_s;

	// split an option word into its fields
	function automatic watchdog_cfg_s decode_option(input logic [31:0] w);
		watchdog_cfg_s c;
		c.auto_start = w[OPT_AUTO_START];
		c.timeout_sel = w[OPT_TIMEOUT_LSB +: 2];
		c.div_sel = w[OPT_DIV_LSB +: 3];
		c.win_end = w[OPT_WIN_END_LSB +: 2];
		c.win_start = w[OPT_WIN_START_LSB +: 2];
		c.action_nmi = w[OPT_ACTION_NMI];
		c.stop_enable = w[OPT_STOP_ENABLE];
		return c;
	endfunction

	// timeout length for a selection code
	function automatic logic [14:0] timeout_len(input logic [1:0] sel);
		case (sel)
			2'd0: timeout_len = TIMEOUT_1024;
			2'd1: timeout_len = TIMEOUT_4096;
			2'd2: timeout_len = TIMEOUT_8192;
			default: timeout_len = TIMEOUT_16384;
		endcase
	endfunction

endpackage

//--- watchdog_down_counter.sv
// one windowed down-counting watchdog with prescaler
`timescale 1ns/1ps
`default_nettype none
module watchdog_down_counter (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration
	input wire watchdog_pkg::watchdog_cfg_s cfg,
	input wire logic [12:0] div_m1,
	// control
	input wire logic count_tick,
	input wire logic freeze,
	input wire logic start,
	input wire logic refresh,
	// state and events
	output logic [13:0] count,
	output logic running,
	output logic underflow,
	output logic refresh_error
);
	import watchdog_pkg::*;

	logic [12:0] prescale; // divider position
	logic step; // one divided count clock
	logic [14:0] top; // timeout length
	logic [14:0] quarter; // a quarter of the down-count
	logic [14:0] start_lim; // counter must be below this
	logic [14:0] end_lim; // counter must be at or above this
	logic in_window; // refresh is allowed now
	logic [13:0] top_m1; // reload value

	// thresholds are multiples of a quarter of the timeout
	always_comb begin
		top = timeout_len(cfg.timeout_sel);
		quarter = top >> 2;
		top_m1 = 14'(top - 15'h0001);
		// start window, code 3 gives no limit
		start_lim = 15'(quarter * ({13'h0000, cfg.win_start} + 15'h0001));
		// end window, code 3 gives no limit
		end_lim = 15'(quarter * (15'h0003 - {13'h0000, cfg.win_end}));
		in_window = ({1'b0, count} < start_lim) && ({1'b0, count} >= end_lim);
	end

	// divided count clock from the source tick
	assign step = running && count_tick && !freeze && (prescale == div_m1);

	// prescaler, cleared while stopped, held while frozen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale <= 13'h0000;
		end else if (!running) begin
			prescale <= 13'h0000;
		end else if (count_tick && !freeze) begin
			prescale <= step ? 13'h0000 : prescale + 13'h0001;
		end
	end

	// counter, run state and event pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 14'h0000;
			running <= 1'b0;
			underflow <= 1'b0;
			refresh_error <= 1'b0;
		end else begin
			underflow <= 1'b0;
			refresh_error <= 1'b0;
			if (!running) begin
				// halted: wait for start or a first refresh
				count <= top_m1;
				running <= start || refresh;
			end else if (refresh) begin
				// reload on every refresh, fault outside the window
				count <= top_m1;
				refresh_error <= !in_window;
			end else if (step) begin
				if (count == 14'h0000) begin
					underflow <= 1'b1;
					count <= top_m1;
				end else begin
					count <= count - 14'h0001;
				end
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_prescale_period: assert property (running |-> prescale <= div_m1)
		else $error("divided clock step off its period");
	a_refresh_window: assert property (running && refresh && !in_window |=> refresh_error)
		else $error("refresh outside window not flagged");
	a_refresh_reload: assert property (running && refresh |=> count == $past(top_m1))
		else $error("refresh did not reload counter");
	a_underflow_cause: assert property (underflow |-> $past(step) && $past(count) == 14'h0000)
		else $error("underflow without counter at zero");
	c_underflow: cover property (underflow);
	c_refresh_ok: cover property (running && refresh && in_window);
endmodule
`default_nettype wire

//--- startup_watchdogs.sv
// two start-up configured windowed watchdogs behind an apb slave
`timescale 1ns/1ps
`default_nettype none
module startup_watchdogs (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// start-up option words
	input wire logic [31:0] startup_option_word_0,
	input wire logic [31:0] startup_option_word_1,
	// count sources and power state
	input wire logic low_speed_onchip_oscillator_tick,
	input wire logic low_power_mode,
	// to the interrupt and reset controllers
	output logic nmi_request,
	output logic reset_request
);
	import watchdog_pkg::*;

	logic cfg_valid; // option words have been captured
	logic boot_start; // one cycle after capture
	logic [31:0] option0; // captured word for independent watchdog
	logic [31:0] option1; // captured word for peripheral watchdog
	watchdog_cfg_s ind_cfg; // decoded independent settings
	watchdog_cfg_s per_cfg; // decoded peripheral settings
	logic [12:0] ind_div_m1; // independent divider minus one
	logic [12:0] per_div_m1; // peripheral divider minus one
	logic wr_access; // write completes this cycle
	logic rd_access; // read completes this cycle
	logic mapped; // address hits a register
	logic ind_refresh; // keyed refresh, independent
	logic per_refresh; // keyed refresh, peripheral
	logic ind_freeze; // independent counter held
	logic [13:0] ind_count;
	logic [13:0] per_count;
	logic ind_running;
	logic per_running;
	logic ind_underflow;
	logic per_underflow;
	logic ind_refresh_err;
	logic per_refresh_err;
	logic ind_event; // independent fault this cycle
	logic per_event; // peripheral fault this cycle
	logic [3:0] flags; // sticky event flags
	logic [3:0] flag_set; // events to record
	logic [3:0] flag_clr; // write-one-to-clear
	logic [31:0] status_word;
	logic [31:0] next_prdata;

	// independent divider: 1, 16, 32, 64, 128, 256
	function automatic logic [12:0] ind_div(input logic [2:0] sel);
		case (sel)
			3'd0: ind_div = 13'h0000;
			3'd1: ind_div = 13'h000F;
			3'd2: ind_div = 13'h001F;
			3'd3: ind_div = 13'h003F;
			3'd4: ind_div = 13'h007F;
			default: ind_div = 13'h00FF;
		endcase
	endfunction

	// peripheral divider: 4, 64, 128, 512, 2048, 8192
	function automatic logic [12:0] per_div(input logic [2:0] sel);
		case (sel)
			3'd0: per_div = 13'h0003;
			3'd1: per_div = 13'h003F;
			3'd2: per_div = 13'h007F;
			3'd3: per_div = 13'h01FF;
			3'd4: per_div = 13'h07FF;
			default: per_div = 13'h1FFF;
		endcase
	endfunction

	// capture the option words once after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_valid <= 1'b0;
			option0 <= 32'h0000_0000;
			option1 <= 32'h0000_0000;
		end else if (!cfg_valid) begin
			cfg_valid <= 1'b1;
			option0 <= startup_option_word_0;
			option1 <= startup_option_word_1;
		end
	end

	// one start pulse just after capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_start <= 1'b0;
		end else begin
			boot_start <= !cfg_valid;
		end
	end

	// decoded settings and divider values
	always_comb begin
		ind_cfg = decode_option(option0);
		per_cfg = decode_option(option1);
		ind_div_m1 = ind_div(ind_cfg.div_sel);
		per_div_m1 = per_div(per_cfg.div_sel);
	end

	// apb decode, zero wait states
	assign pready = 1'b1;
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && penable && !pwrite;
	assign ind_refresh = cfg_valid && wr_access && paddr == IND_REFRESH_OFS && pwdata == REFRESH_KEY;
	assign per_refresh = cfg_valid && wr_access && paddr == PER_REFRESH_OFS && pwdata == REFRESH_KEY;

	// address hit check
	always_comb begin
		case (paddr)
			IND_REFRESH_OFS, PER_REFRESH_OFS, STATUS_OFS: mapped = 1'b1;
			IND_COUNT_OFS, PER_COUNT_OFS: mapped = 1'b1;
			OPTION0_OFS, OPTION1_OFS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// unmapped addresses answer with an error
	assign pslverr = psel && penable && !mapped;

	assign ind_freeze = ind_cfg.stop_enable && low_power_mode;

	// independent watchdog on the oscillator tick
	watchdog_down_counter u_ind (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(ind_cfg),
		.div_m1(ind_div_m1),
		.count_tick(low_speed_onchip_oscillator_tick),
		.freeze(ind_freeze),
		.start(boot_start && ind_cfg.auto_start),
		.refresh(ind_refresh),
		.count(ind_count),
		.running(ind_running),
		.underflow(ind_underflow),
		.refresh_error(ind_refresh_err)
	);

	// peripheral watchdog counts every peripheral clock
	watchdog_down_counter u_per (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(per_cfg),
		.div_m1(per_div_m1),
		.count_tick(1'b1),
		.freeze(1'b0),
		.start(boot_start && per_cfg.auto_start),
		.refresh(per_refresh),
		.count(per_count),
		.running(per_running),
		.underflow(per_underflow),
		.refresh_error(per_refresh_err)
	);

	// a window fault acts like an underflow
	assign ind_event = ind_underflow || ind_refresh_err;
	assign per_event = per_underflow || per_refresh_err;

	// nmi is a one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_request <= 1'b0;
		end else begin
			// route each fault to its chosen action
			nmi_request <= (ind_event && ind_cfg.action_nmi) ||
				(per_event && per_cfg.action_nmi);
		end
	end

	// reset request holds until the system reset arrives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_request <= 1'b0;
		end else if ((ind_event && !ind_cfg.action_nmi) ||
			(per_event && !per_cfg.action_nmi)) begin
			reset_request <= 1'b1;
		end
	end

	// sticky flags, set wins over clear
	always_comb begin
		flag_set = {per_refresh_err, per_underflow, ind_refresh_err, ind_underflow};
		flag_clr = 4'h0;
		if (wr_access && paddr == STATUS_OFS) begin
			flag_clr = pwdata[ST_PER_REFRESH_ERR:ST_IND_UNDERFLOW];
		end
	end

	// flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= 4'h0;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	// status word assembly
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_IND_RUN] = ind_running;
		status_word[ST_PER_RUN] = per_running;
		status_word[ST_PER_REFRESH_ERR:ST_IND_UNDERFLOW] = flags;
	end

	// read mux, registered for the next access phase
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			STATUS_OFS: next_prdata = status_word;
			IND_COUNT_OFS: next_prdata = {18'h0_0000, ind_count};
			PER_COUNT_OFS: next_prdata = {18'h0_0000, per_count};
			OPTION0_OFS: next_prdata = option0;
			OPTION1_OFS: next_prdata = option1;
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// start-up state and load values
	a_ind_autostart: assert property ($rose(cfg_valid) |=> ind_running == ind_cfg.auto_start)
		else $error("independent start state wrong after capture");
	a_per_autostart: assert property ($rose(cfg_valid) |=> per_running == per_cfg.auto_start)
		else $error("peripheral start state wrong after capture");
	a_ind_timeout: assert property ($rose(ind_running) |-> {1'b0, ind_count} ==
		15'(timeout_len(ind_cfg.timeout_sel) - 15'h0001))
		else $error("independent timeout load wrong");
	a_per_timeout: assert property ($rose(per_running) |-> {1'b0, per_count} ==
		15'(timeout_len(per_cfg.timeout_sel) - 15'h0001))
		else $error("peripheral timeout load wrong");
	// fault routing, count-stop and held option words
	a_ind_action: assert property (ind_event |=> ind_cfg.action_nmi ? nmi_request : reset_request)
		else $error("independent fault action missing");
	a_per_action: assert property (per_event |=> per_cfg.action_nmi ? nmi_request : reset_request)
		else $error("peripheral fault action missing");
	a_count_stop: assert property (ind_running && ind_freeze && !ind_refresh |=> $stable(ind_count))
		else $error("independent counter moved while frozen");
	a_options_held: assert property (cfg_valid |=> $stable(option0) && $stable(option1))
		else $error("option words changed while running");
	a_refresh_fault: assert property (ind_running && ind_refresh ##1 ind_refresh_err
		|=> ind_cfg.action_nmi ? nmi_request : reset_request)
		else $error("window fault did not act");
	a_per_refresh_fault: assert property (per_running && per_refresh ##1 per_refresh_err
		|=> per_cfg.action_nmi ? nmi_request : reset_request)
		else $error("peripheral window fault did not act");
	// read-back shows the state seen at the setup edge
	a_read_option: assert property (rd_access && paddr == OPTION1_OFS && $past(cfg_valid) |-> prdata == option1)
		else $error("option word read-back wrong");
	a_status_run: assert property (rd_access && paddr == STATUS_OFS |->
		prdata[ST_PER_RUN:ST_IND_RUN] == $past({per_running, ind_running}))
		else $error("run bits read back wrong");
	// faults leave their marks until cleared or reset
	a_reset_sticky: assert property (reset_request |=> reset_request)
		else $error("reset request dropped");
	a_flag_set_wins: assert property (ind_underflow |=> flags[0])
		else $error("underflow flag not recorded");
	c_reset_req: cover property ($rose(reset_request));
	c_nmi: cover property (nmi_request);
	c_ind_frozen: cover property (ind_running && ind_freeze);
endmodule
`default_nettype wire

//--- reset_nmi_model.sv
// far-side model of the system reset and interrupt controllers
`timescale 1ns/1ps
`default_nettype none
module reset_nmi_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requests from the watchdog pair
	input wire logic nmi_request,
	input wire logic reset_request,
	// what the controllers have taken
	output var int nmi_count,
	output logic reset_seen
);
	// take each interrupt pulse once and latch a reset request
	// either action accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_count <= 0;
			reset_seen <= 1'b0;
		end else begin
			// a pulse held longer than one cycle would count twice
			if (nmi_request)
				nmi_count <= nmi_count + 1;
			// a reset request is never dropped once seen
			if (reset_request)
				reset_seen <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- tb_startup_configured_windowed_watchdogs.sv
// self-checking bench for the start-up configured watchdog pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("[FAIL] %0t mismatch at line %0d", $time, `__LINE__); \
	end \
end
module tb_startup_configured_windowed_watchdogs;
	import watchdog_pkg::*;
	// apb master and option inputs
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] opt0 = 32'h0000_0000;
	logic [31:0] opt1 = 32'h0000_0000;
	logic osc_tick = 1'b1;
	logic lp = 1'b0;
	// design outputs and partner view
	logic [31:0] prdata;
	logic pready, pslverr, nmi_request, reset_request, reset_seen;
	int nmi_count;
	// bookkeeping
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h0000_67E4;
	logic [31:0] rd, rv, c0, c1, o0;
	logic er;
	int n, e, t;
	// expected timeout lengths and divider factors
	int tlen[4] = '{1024, 4096, 8192, 16384};
	int idiv[6] = '{1, 16, 32, 64, 128, 256};
	int pdiv[6] = '{4, 64, 128, 512, 2048, 8192};

	// 20 MHz clock
	always #25 pclk = ~pclk;

	startup_watchdogs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .startup_option_word_0(opt0), .startup_option_word_1(opt1),
		.low_speed_onchip_oscillator_tick(osc_tick), .low_power_mode(lp),
		.nmi_request(nmi_request), .reset_request(reset_request));
	reset_nmi_model partner (.pclk(pclk), .presetn(presetn), .nmi_request(nmi_request),
		.reset_request(reset_request), .nmi_count(nmi_count), .reset_seen(reset_seen));

	// xorshift source with a fixed start
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// build an option word from its fields
	function automatic logic [31:0] optw(input logic a, input logic [1:0] t,
		input logic [2:0] d, input logic [1:0] we, input logic [1:0] ws,
		input logic nm, input logic st);
		return {20'h0_0000, st, nm, ws, we, d, t, a};
	endfunction

	// true when a value lies in an expected band
	function automatic logic inr(input logic [31:0] v, input int lo, input int hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// reset with new option words, wait until the watchdogs are live
	task automatic rst(input logic [31:0] a, input logic [31:0] b);
		@(posedge pclk);
		presetn <= 1'b0;
		opt0 <= a;
		opt1 <= b;
		lp <= 1'b0;
		osc_tick <= 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	// count cycles until nmi (sel 0) or reset (sel 1) shows, bounded
	task automatic wait_sig(input logic sel, input int lim);
		n = 0;
		forever begin
			@(posedge pclk);
			n++;
			if ((sel ? reset_request : nmi_request) === 1'b1 || n >= lim)
				break;
		end
	endtask

	// print the verdict and stop
	task automatic finish_test();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// hang guard, well beyond the expected run
	initial begin
		#2ms;
		n_errors++;
		$display("[FAIL] %0t run did not complete", $time);
		finish_test();
	end

	initial begin
		// halted start, captured options, unmapped access
		o0 = 32'h0000_0FFE;
		rst(o0, 32'h0000_0AAA);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK(rd[1:0], 2'b00)
		opt0 <= 32'h0000_0123;
		apb(1'b0, OPTION0_OFS, 32'h0);
		`CHK(rd, o0)
		apb(1'b0, 8'h1C, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0000_0000})
		apb(1'b1, PER_REFRESH_OFS, REFRESH_KEY);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK(rd[ST_PER_RUN], 1'b1)
		$display("test halted start done");
		// every timeout code, read as the loaded count
		for (int k = 0; k < 4; k++) begin
			rst(optw(1, 2'(k), 0, 3, 3, 1, 0), optw(1, 2'(k), 0, 3, 3, 1, 0));
			apb(1'b0, STATUS_OFS, 32'h0);
			`CHK(rd[1:0], 2'b11)
			apb(1'b0, IND_COUNT_OFS, 32'h0);
			`CHK(inr(rd, tlen[k] - 8, tlen[k] - 1), 1'b1)
			apb(1'b0, PER_COUNT_OFS, 32'h0);
			`CHK(inr(rd, tlen[k] - 4, tlen[k] - 1), 1'b1)
		end
		$display("test timeout codes done");
		// divider codes 0 to 5, random low power with count-stop off
		for (int d = 0; d < 6; d++) begin
			rst(optw(1, 3, 3'(d), 3, 3, 1, 0), optw(1, 3, 3'(d), 3, 3, 1, 0));
			apb(1'b0, IND_COUNT_OFS, 32'h0);
			c0 = rd;
			apb(1'b0, PER_COUNT_OFS, 32'h0);
			c1 = rd;
			t = 0;
			repeat (2560) begin
				@(posedge pclk);
				rv = xorshift();
				lp <= rv[0];
				osc_tick <= rv[1];
				t += rv[1];
			end
			apb(1'b0, IND_COUNT_OFS, 32'h0);
			// six oscillator ticks stand around the two reads
			e = (t + 6) / idiv[d];
			`CHK(inr(c0 - rd, e - 1, e + 1), 1'b1)
			apb(1'b0, PER_COUNT_OFS, 32'h0);
			e = 2566 / pdiv[d];
			`CHK(inr(c1 - rd, (e > 0) ? e - 1 : 0, e + 1), 1'b1)
		end
		$display("test dividers done");
		// open window refresh, then underflow to nmi, then freeze
		rst(optw(1, 0, 0, 3, 3, 1, 1), 32'h0000_0000);
		apb(1'b1, IND_REFRESH_OFS, REFRESH_KEY);
		wait_sig(1'b0, 1100);
		`CHK(inr(n, 1018, 1032), 1'b1)
		@(posedge pclk);
		`CHK({reset_request, nmi_count}, {1'b0, 32'sd1})
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK(rd[ST_IND_UNDERFLOW], 1'b1)
		lp <= 1'b1;
		apb(1'b0, IND_COUNT_OFS, 32'h0);
		c0 = rd;
		repeat (300) @(posedge pclk);
		apb(1'b0, IND_COUNT_OFS, 32'h0);
		`CHK(rd, c0)
		lp <= 1'b0;
		$display("test nmi and freeze done");
		// peripheral underflow to a sticky reset
		rst(32'h0000_0000, optw(1, 0, 0, 3, 3, 0, 0));
		wait_sig(1'b1, 4200);
		`CHK(inr(n, 4088, 4108), 1'b1)
		repeat (20) @(posedge pclk);
		`CHK({reset_request, reset_seen, nmi_count}, {2'b11, 32'sd0})
		$display("test reset action done");
		// window from 75 down to 50 percent: early refresh faults
		o0 = optw(1, 0, 0, 1, 2, 1, 0);
		rst(o0, 32'h0000_0000);
		apb(1'b1, IND_REFRESH_OFS, REFRESH_KEY);
		wait_sig(1'b0, 8);
		`CHK(inr(n, 1, 6), 1'b1)
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK(rd[ST_IND_REFRESH_ERR], 1'b1)
		// a refresh at a random point inside the window reloads
		rst(o0, 32'h0000_0000);
		apb(1'b0, IND_COUNT_OFS, 32'h0);
		rv = xorshift();
		repeat (rd - 560 - rv[6:0]) @(posedge pclk);
		apb(1'b1, IND_REFRESH_OFS, REFRESH_KEY);
		apb(1'b0, IND_COUNT_OFS, 32'h0);
		`CHK(inr(rd, 1010, 1023), 1'b1)
		`CHK(nmi_count, 0)
		// a refresh after the window end faults as well
		repeat (600) @(posedge pclk);
		apb(1'b1, IND_REFRESH_OFS, REFRESH_KEY);
		wait_sig(1'b0, 8);
		`CHK(inr(n, 1, 6), 1'b1)
		$display("test refresh window done");
		finish_test();
	end
endmodule
`default_nettype wire
